// ---- logic/tcd_pkg.sv ----
// Constants shared by the two-channel transfer engine and its channels.
// Assumes nothing beyond a SystemVerilog compiler.
package tcd_pkg;

  localparam int unsigned NCH = 2;

  // Register selectors for the channel write/read port
  localparam logic [2:0] REG_SRC_LO = 3'h0;
  localparam logic [2:0] REG_SRC_HI = 3'h1;
  localparam logic [2:0] REG_DST_LO = 3'h2;
  localparam logic [2:0] REG_DST_HI = 3'h3;
  localparam logic [2:0] REG_COUNT = 3'h4;
  localparam logic [2:0] REG_CTL = 3'h5;

  // Control register fields
  localparam int unsigned CTL_ARM = 0;
  localparam int unsigned CTL_WORD = 1;
  localparam int unsigned CTL_TC_STOP = 2;
  localparam int unsigned CTL_IRQ_EN = 3;
  localparam int unsigned CTL_PRIO = 4;
  localparam int unsigned CTL_SYNC_LSB = 5;
  localparam int unsigned CTL_RSRC_LSB = 7;
  localparam int unsigned CTL_SSTEP_LSB = 9;
  localparam int unsigned CTL_SRC_IO = 11;
  localparam int unsigned CTL_DSTEP_LSB = 12;
  localparam int unsigned CTL_DST_IO = 14;

  localparam logic [1:0] STEP_HOLD = 2'h0;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_DEC = 2'h2;

  localparam logic [1:0] SYNC_NONE = 2'h0;
  localparam logic [1:0] SYNC_SRC = 2'h1;
  localparam logic [1:0] SYNC_DST = 2'h2;

  localparam logic [1:0] RSRC_PIN = 2'h0;
  localparam logic [1:0] RSRC_TMR = 2'h1;
  localparam logic [1:0] RSRC_SW = 2'h2;

  // Reset values
  localparam logic [19:0] PTR_RST = 20'h00000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CTL_RST = 16'h0000;

  // Each bus cycle lasts at least four clocks, two per transfer
  localparam logic [1:0] BUS_CNT_LAST = 2'h3;
  localparam logic [15:0] CNT_LAST_XFER = 16'h0001;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_DEPOSIT = 2'h3
  } tcd_state_e;

endpackage

// ---- logic/tcd_chan_if.sv ----
// Bundle between the transfer engine and one channel register set.
// Assumes one engine end and one channel end per instance.
`timescale 1ns/10ps
`default_nettype none
interface tcd_chan_if;
  logic wr;
  logic [2:0] sel;
  logic [15:0] wdata;
  logic done;
  logic [19:0] src_ptr;
  logic [19:0] dst_ptr;
  logic [15:0] count;
  logic [15:0] ctl;
  logic irq;

  modport eng (
    output wr, sel, wdata, done,
    input src_ptr, dst_ptr, count, ctl, irq
  );
  modport chan (
    input wr, sel, wdata, done,
    output src_ptr, dst_ptr, count, ctl, irq
  );
endinterface
`default_nettype wire

// ---- logic/tcd_chan.sv ----
// One channel: pointers, transfer count and control register.
// Assumes the engine pulses done once per finished transfer.
`timescale 1ns/10ps
`default_nettype none
module tcd_chan
  import tcd_pkg::*;
#(
  parameter bit BUS_16 = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  tcd_chan_if.chan ch
);

  logic [19:0] src_q;
  logic [19:0] dst_q;
  logic [15:0] cnt_q;
  logic [15:0] ctl_q;
  logic irq_q;
  logic word;
  logic tc_evt;
  logic [19:0] src_nx;
  logic [19:0] dst_nx;
  logic [15:0] cnt_nx;

  function automatic logic [19:0] step_ptr(input logic [19:0] p,
                                           input logic [1:0] st,
                                           input logic w);
    logic [19:0] d;
    d = w ? 20'h00002 : 20'h00001;
    unique case (st)
      STEP_INC: step_ptr = p + d;
      STEP_DEC: step_ptr = p - d;
      default: step_ptr = p;
    endcase
  endfunction

  function automatic logic hit(input logic [2:0] s);
    hit = ch.wr && (ch.sel == s);
  endfunction

  // ----------------------------------------------------------------
  // Pointer and count update; a write in the same cycle wins
  // ----------------------------------------------------------------
  assign word = ctl_q[CTL_WORD] & BUS_16;
  assign src_nx = ch.done ? step_ptr(src_q,
    ctl_q[CTL_SSTEP_LSB +: 2], word) : src_q;
  assign dst_nx = ch.done ? step_ptr(dst_q,
    ctl_q[CTL_DSTEP_LSB +: 2], word) : dst_q;
  assign cnt_nx = ch.done ? cnt_q - 16'h0001 : cnt_q;
  assign tc_evt = ch.done && (cnt_q == CNT_LAST_XFER);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_q <= PTR_RST;
    end else if (i_clk_en) begin
      if (hit(REG_SRC_LO)) begin
        src_q <= {src_nx[19:16], ch.wdata};
      end else if (hit(REG_SRC_HI)) begin
        src_q <= {ch.wdata[3:0], src_nx[15:0]};
      end else begin
        src_q <= src_nx;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dst_q <= PTR_RST;
    end else if (i_clk_en) begin
      if (hit(REG_DST_LO)) begin
        dst_q <= {dst_nx[19:16], ch.wdata};
      end else if (hit(REG_DST_HI)) begin
        dst_q <= {ch.wdata[3:0], dst_nx[15:0]};
      end else begin
        dst_q <= dst_nx;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= CNT_RST;
    end else if (i_clk_en) begin
      cnt_q <= hit(REG_COUNT) ? ch.wdata : cnt_nx;
    end
  end

  // Software re-arming in the terminal cycle beats the self clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_q <= CTL_RST;
    end else if (i_clk_en) begin
      if (hit(REG_CTL)) begin
        ctl_q <= ch.wdata;
      end else if (tc_evt && ctl_q[CTL_TC_STOP]) begin
        ctl_q[CTL_ARM] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else if (i_clk_en) begin
      irq_q <= tc_evt && ctl_q[CTL_IRQ_EN];
    end
  end

  assign ch.src_ptr = src_q;
  assign ch.dst_ptr = dst_q;
  assign ch.count = cnt_q;
  assign ch.ctl = ctl_q;
  assign ch.irq = irq_q;

endmodule
`default_nettype wire

// ---- logic/tcd_engine.sv ----
// Two-channel transfer engine: request selection, arbitration and
// the fetch/deposit bus sequencer.
// Assumes a bus unit that honours o_bus_cyc and answers i_bus_rdy.
//
// Notes on behaviour
// - Two independent channels, each with its own register set.
// - Source and destination each in memory or I/O space, any mix.
// - Byte or word moves on a 16-bit bus; bytes only on 8-bit bus.
// - A transfer is one fetch plus one deposit, eight clocks at least.
// - One selected request source: pin, timer 2 or software.
// - 20-bit source and destination, 16-bit count and control each.
// - Count sets transfers, up to 64K, and marks the end when it runs out.
// - Registers stay writable mid-transfer and act at once.
// - Control picks unsynchronized, source or destination sync.
// - Optional interrupt request after the last counted transfer.
// - Optional stop when the count is used up; else keep going.
// - Source pointer steps up, down or holds; memory or I/O.
// - Destination pointer steps up, down or holds; memory or I/O.
// - Higher priority wins; equal priority alternates transfers.
// - Engine beats CPU, but not inside locked accesses.
// - External bus hold wins; engine waits for its release.
// - Maskable interrupts do not suspend a transfer sequence.
// - NMI holds off every new bus cycle on both channels; a started cycle runs to its end.
`timescale 1ns/10ps
`default_nettype none
module tcd_engine
  import tcd_pkg::*;
#(
  parameter bit BUS_16 = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_reg_ch,
  input wire logic [2:0] i_reg_sel,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic [1:0] i_channel_request_pins,
  input wire logic i_timer2_req,
  input wire logic i_hold_req,
  input wire logic i_cpu_lock,
  input wire logic i_nmi,
  output logic o_bus_req,
  output logic o_bus_cyc,
  output logic [19:0] o_bus_addr,
  output logic o_bus_io,
  output logic o_bus_wr,
  output logic [1:0] o_bus_be,
  output logic [15:0] o_bus_wdata,
  input wire logic i_bus_rdy,
  input wire logic [15:0] i_bus_rdata,
  output logic [1:0] o_irq,
  output logic o_busy,
  output logic o_active_ch,
  output logic [1:0] o_chan_armed
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tcd_state_e state_q;
  logic ch_q;
  logic last_q;
  logic cyc_q;
  logic [1:0] clk_cnt_q;
  logic [15:0] data_q;
  logic [19:0] addr_q;
  logic io_q;
  logic wr_q;
  logic [1:0] be_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [1:0] tmr_pend_q;

  logic [1:0] armed;
  logic [1:0] prio;
  logic [1:0] word;
  logic [1:0] req_lvl;
  logic [1:0] fetch_ok;
  logic [1:0] dep_ok;
  logic [1:0] done;
  logic bus_free;
  logic cyc_end;
  logic start_fetch;
  logic start_dep;
  logic pick;

  logic [19:0] src_ptr [NCH];
  logic [19:0] dst_ptr [NCH];
  logic [15:0] ctl [NCH];
  logic [15:0] count [NCH];

  tcd_chan_if chif [NCH] ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte moves use the lane picked by address bit 0
  function automatic logic [1:0] lanes(input logic w, input logic a0);
    if (w) begin
      lanes = 2'h3;
    end else begin
      lanes = a0 ? 2'h2 : 2'h1;
    end
  endfunction

  function automatic logic [15:0] rd_mux(input logic [2:0] s,
                                         input logic [19:0] sp,
                                         input logic [19:0] dp,
                                         input logic [15:0] cn,
                                         input logic [15:0] ct);
    unique case (s)
      REG_SRC_LO: rd_mux = sp[15:0];
      REG_SRC_HI: rd_mux = {12'h000, sp[19:16]};
      REG_DST_LO: rd_mux = dp[15:0];
      REG_DST_HI: rd_mux = {12'h000, dp[19:16]};
      REG_COUNT: rd_mux = cn;
      REG_CTL: rd_mux = ct;
      default: rd_mux = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    tcd_chan #(
      .BUS_16(BUS_16)
    ) u_chan (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .ch(chif[g])
    );

    assign chif[g].wr = i_reg_wr && (i_reg_ch == 1'(g));
    assign chif[g].sel = i_reg_sel;
    assign chif[g].wdata = i_reg_wdata;
    assign chif[g].done = done[g];

    assign src_ptr[g] = chif[g].src_ptr;
    assign dst_ptr[g] = chif[g].dst_ptr;
    assign ctl[g] = chif[g].ctl;
    assign count[g] = chif[g].count;
    assign o_irq[g] = chif[g].irq;

    assign armed[g] = ctl[g][CTL_ARM];
    assign prio[g] = ctl[g][CTL_PRIO];
    assign word[g] = ctl[g][CTL_WORD] & BUS_16;

    // At most one source feeds the channel request; the unused code feeds none
    always_comb begin
      unique case (ctl[g][CTL_RSRC_LSB +: 2])
        RSRC_PIN: req_lvl[g] = i_channel_request_pins[g];
        RSRC_TMR: req_lvl[g] = tmr_pend_q[g];
        RSRC_SW: req_lvl[g] = 1'b1;
        default: req_lvl[g] = 1'b0;
      endcase
    end

    // Source sync gates the fetch, destination sync gates the deposit
    assign fetch_ok[g] = armed[g] &&
      (ctl[g][CTL_SYNC_LSB +: 2] != SYNC_SRC || req_lvl[g]);
    assign dep_ok[g] =
      ctl[g][CTL_SYNC_LSB +: 2] != SYNC_DST || req_lvl[g];

    assign done[g] = cyc_end && (state_q == ST_DEPOSIT) &&
      (ch_q == 1'(g));

    // Timer pulses are held until that channel completes a transfer
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        tmr_pend_q[g] <= 1'b0;
      end else if (i_clk_en) begin
        if (i_timer2_req) begin
          tmr_pend_q[g] <= 1'b1;
        end else if (done[g]) begin
          tmr_pend_q[g] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Maskable interrupts have no input here, so they cannot stall us
  assign bus_free = !i_hold_req && !i_cpu_lock &&
    !i_nmi;

  always_comb begin
    if (fetch_ok == 2'h3) begin
      if (prio[0] != prio[1]) begin
        pick = prio[1];
      end else begin
        pick = ~last_q;
      end
    end else begin
      pick = fetch_ok[1];
    end
  end

  assign start_fetch = (state_q == ST_FETCH) && !cyc_q && bus_free;
  assign start_dep = (state_q == ST_DEPOSIT) && !cyc_q && bus_free &&
    dep_ok[ch_q];
  assign cyc_end = cyc_q && (clk_cnt_q == BUS_CNT_LAST) && i_bus_rdy;

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      ch_q <= 1'b0;
      last_q <= 1'b1;
    end else if (i_clk_en) begin
      unique case (state_q)
        ST_IDLE: begin
          if (fetch_ok != 2'h0 && bus_free) begin
            state_q <= ST_FETCH;
            ch_q <= pick;
            last_q <= pick;
          end
        end
        ST_FETCH: begin
          if (!cyc_q && !armed[ch_q]) begin
            state_q <= ST_IDLE;
          end else if (cyc_end) begin
            state_q <= ST_DEPOSIT;
          end
        end
        ST_DEPOSIT: begin
          if (!cyc_q && !armed[ch_q]) begin
            state_q <= ST_IDLE;
          end else if (cyc_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // A started cycle always runs to its end so the bus is never torn
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_q <= 1'b0;
    end else if (i_clk_en) begin
      if (start_fetch || start_dep) begin
        cyc_q <= 1'b1;
      end else if (cyc_end) begin
        cyc_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_cnt_q <= 2'h0;
    end else if (i_clk_en) begin
      if (start_fetch || start_dep) begin
        clk_cnt_q <= 2'h0;
      end else if (cyc_q && clk_cnt_q != BUS_CNT_LAST) begin
        clk_cnt_q <= clk_cnt_q + 2'h1;
      end
    end
  end

  // Address and qualifiers are frozen for the whole bus cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_q <= PTR_RST;
      io_q <= 1'b0;
      wr_q <= 1'b0;
      be_q <= 2'h0;
    end else if (i_clk_en) begin
      if (start_fetch) begin
        addr_q <= src_ptr[ch_q];
        io_q <= ctl[ch_q][CTL_SRC_IO];
        wr_q <= 1'b0;
        be_q <= lanes(word[ch_q], src_ptr[ch_q][0]);
      end else if (start_dep) begin
        addr_q <= dst_ptr[ch_q];
        io_q <= ctl[ch_q][CTL_DST_IO];
        wr_q <= 1'b1;
        be_q <= lanes(word[ch_q], dst_ptr[ch_q][0]);
      end
    end
  end

  // Fetched byte is normalised to the low lane, then mirrored out
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_q <= 16'h0000;
    end else if (i_clk_en) begin
      if (cyc_end && state_q == ST_FETCH) begin
        if (be_q == 2'h2) begin
          data_q <= {8'h00, i_bus_rdata[15:8]};
        end else begin
          data_q <= i_bus_rdata;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdata_q <= 16'h0000;
    end else if (i_clk_en) begin
      if (start_dep) begin
        if (word[ch_q]) begin
          wdata_q <= data_q;
        end else begin
          wdata_q <= {data_q[7:0], data_q[7:0]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read-back
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 16'h0000;
    end else if (i_clk_en) begin
      if (i_reg_rd) begin
        rdata_q <= rd_mux(i_reg_sel, src_ptr[i_reg_ch],
          dst_ptr[i_reg_ch], count[i_reg_ch], ctl[i_reg_ch]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata = rdata_q;
  assign o_bus_req = (state_q != ST_IDLE) || (fetch_ok != 2'h0);
  assign o_bus_cyc = cyc_q;
  assign o_bus_addr = addr_q;
  assign o_bus_io = io_q;
  assign o_bus_wr = wr_q;
  assign o_bus_be = be_q;
  assign o_bus_wdata = wdata_q;
  assign o_busy = state_q != ST_IDLE;
  assign o_active_ch = ch_q;
  assign o_chan_armed = armed;

endmodule
`default_nettype wire

// ---- testbench/tcd_bus_model.sv ----
// Memory and I/O peripheral model for the engine's system bus.
// Assumes one engine as the only bus master.
`timescale 1ns/10ps
`default_nettype none
module tcd_bus_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_cyc,
  input wire logic i_wr,
  input wire logic [19:0] i_addr,
  input wire logic [2:0] i_wait,
  output logic o_rdy,
  output logic [15:0] o_rdata
);
  logic [3:0] cnt_q;
  logic [15:0] last_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 4'h0;
      last_q <= 16'h0000;
    end else begin
      cnt_q <= i_cyc ? cnt_q + 4'h1 : 4'h0;
      last_q <= o_rdata;
    end
  end
  // Wait states stretch the cycle; ready only inside a cycle
  assign o_rdy = i_cyc && (cnt_q >= {1'b0, i_wait});
  // Same answer in both spaces; released bus toggles, never holds
  assign o_rdata = (i_cyc && !i_wr) ?
    ({i_addr[7:1], 1'b1, i_addr[7:1], 1'b0} ^ 16'h3CC3) : ~last_q;
endmodule
`default_nettype wire

// ---- testbench/tcd_engine_monitor.sv ----
// Port checker for the transfer engine.
// Assumes it is bound into tcd_engine.
`timescale 1ns/10ps
`default_nettype none
module tcd_engine_monitor #(
  parameter bit BUS_16 = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_rd,
  input wire logic i_hold_req,
  input wire logic i_cpu_lock,
  input wire logic i_nmi,
  input wire logic o_bus_cyc,
  input wire logic [19:0] o_bus_addr,
  input wire logic o_bus_wr,
  input wire logic [1:0] o_bus_be,
  input wire logic [15:0] o_reg_rdata,
  input wire logic [1:0] o_irq
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_min_len;
    $rose(o_bus_cyc) |-> o_bus_cyc[*4];
  endproperty
  a_min_len: assert property (p_min_len) else $error("short cycle");
  property p_addr_hold;
    o_bus_cyc && $past(o_bus_cyc) |-> $stable(o_bus_addr) && $stable(o_bus_wr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
  property p_hold;
    $rose(o_bus_cyc) |-> !$past(i_hold_req);
  endproperty
  a_hold: assert property (p_hold) else $error("cycle under hold");
  property p_lock;
    $rose(o_bus_cyc) |-> !$past(i_cpu_lock);
  endproperty
  a_lock: assert property (p_lock) else $error("cycle under lock");
  property p_nmi;
    $rose(o_bus_cyc) |-> !$past(i_nmi);
  endproperty
  a_nmi: assert property (p_nmi) else $error("cycle under nmi");
  property p_dep_after_fetch;
    $rose(o_bus_cyc) && o_bus_wr |-> !$past(o_bus_wr);
  endproperty
  a_dep_after_fetch: assert property (p_dep_after_fetch)
    else $error("no fetch");
  property p_be;
    o_bus_cyc |-> o_bus_be != 2'h0 && (BUS_16 || o_bus_be != 2'h3);
  endproperty
  a_be: assert property (p_be) else $error("bad lanes");
  property p_irq_pulse;
    o_irq != 2'h0 |=> o_irq == 2'h0;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq too long");
  property p_irq_cause;
    o_irq != 2'h0 |-> $past(o_bus_cyc) && o_bus_wr;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq no deposit");
  property p_rdata;
    !$past(i_reg_rd) |-> $stable(o_reg_rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("rdata moved");
  c_fetch: cover property ($rose(o_bus_cyc) && !o_bus_wr);
  c_dep: cover property ($rose(o_bus_cyc) && o_bus_wr);
  c_irq: cover property (o_irq != 2'h0);
endmodule
bind tcd_engine tcd_engine_monitor #(.BUS_16(BUS_16)) u_mon (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg_rd(i_reg_rd),
  .i_hold_req(i_hold_req), .i_cpu_lock(i_cpu_lock), .i_nmi(i_nmi),
  .o_bus_cyc(o_bus_cyc), .o_bus_addr(o_bus_addr), .o_bus_wr(o_bus_wr),
  .o_bus_be(o_bus_be), .o_reg_rdata(o_reg_rdata), .o_irq(o_irq));
`default_nettype wire

// ---- testbench/tb_two_channel_dma_unit.sv ----
// Self-checking bench for the two-channel transfer engine.
// Assumes the bus model answers every cycle, promptly or slowly.
`timescale 1ns/10ps
`default_nettype none
module tb_two_channel_dma_unit;
  import tcd_pkg::*;
  logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, ch = 0, tmr = 0, en = 1;
  logic hold = 0, lock = 0, nmi = 0, cyc_p = 0, breq, cyc, io, bwr;
  logic rdy, busy, act, dio;
  logic [2:0] sel = 0, wt = 0;
  logic [15:0] wd = 0, rdata, bwd, brd, dep_d;
  logic [1:0] pins = 0, be, irq, armed, fbe, dbe, irqs = 0;
  logic [19:0] addr, dep_a;
  logic [3:0] seq = 0;
  int n_mismatch = 0, comparisons = 0, nf = 0, nd = 0, ticks = 0;
  always #5 clk = ~clk;
  tcd_engine u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(en),
    .i_reg_wr(wr_s), .i_reg_rd(rd_s), .i_reg_ch(ch), .i_reg_sel(sel),
    .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_channel_request_pins(pins),
    .i_timer2_req(tmr), .i_hold_req(hold), .i_cpu_lock(lock), .i_nmi(nmi),
    .o_bus_req(breq), .o_bus_cyc(cyc), .o_bus_addr(addr), .o_bus_io(io),
    .o_bus_wr(bwr), .o_bus_be(be), .o_bus_wdata(bwd), .i_bus_rdy(rdy),
    .i_bus_rdata(brd), .o_irq(irq), .o_busy(busy), .o_active_ch(act),
    .o_chan_armed(armed));
  tcd_bus_model u_bus (.i_core_clk(clk), .i_rst_n(rst_n), .i_cyc(cyc),
    .i_wr(bwr), .i_addr(addr), .i_wait(wt), .o_rdy(rdy), .o_rdata(brd));
  // Cycle starts seen on the bus; also the hang limit
  always @(posedge clk) begin
    cyc_p <= cyc;
    irqs <= irqs | irq;
    ticks <= ticks + 1;
    if (cyc && !cyc_p && !bwr) begin
      nf <= nf + 1;
      seq <= {seq[2:0], act};
      fbe <= be;
    end
    if (cyc && !cyc_p && bwr) begin
      nd <= nd + 1;
      dep_a <= addr;
      dep_d <= bwd;
      dio <= io;
      dbe <= be;
    end
    if (ticks > 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  function automatic logic [15:0] pat(input logic [19:0] a);
    pat = {a[7:1], 1'b1, a[7:1], 1'b0} ^ 16'h3CC3;
  endfunction
  function automatic logic [15:0] ctlw(input logic [1:0] sy, rs, ss, ds,
      input logic w, st, ie, pr, si, di);
    ctlw = {1'b0, di, ds, si, ss, rs, sy, pr, ie, st, w, 1'b1};
  endfunction
  task automatic chk(input string nm, input logic [19:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic c, input logic [2:0] s,
      input logic [15:0] d);
    @(negedge clk);
    wr_s = 1;
    ch = c;
    sel = s;
    wd = d;
    @(negedge clk);
    wr_s = 0;
  endtask
  task automatic rchk(input string nm, input logic c, input logic [2:0] s,
      input logic [15:0] e);
    @(negedge clk);
    rd_s = 1;
    ch = c;
    sel = s;
    @(negedge clk);
    rd_s = 0;
    chk(nm, {4'h0, e}, {4'h0, rdata});
  endtask
  task automatic setup(input logic c, input logic [19:0] s, d,
      input logic [15:0] n, k);
    wreg(c, REG_SRC_LO, s[15:0]);
    wreg(c, REG_SRC_HI, {12'h000, s[19:16]});
    wreg(c, REG_DST_LO, d[15:0]);
    wreg(c, REG_DST_HI, {12'h000, d[19:16]});
    wreg(c, REG_COUNT, n);
    wreg(c, REG_CTL, k);
  endtask
  task automatic wait_n(input bit dep, input int t);
    for (int k = 0; k < 3000 && (dep ? nd : nf) < t; k++) @(negedge clk);
    chk("cycle count", 20'(t), 20'(dep ? nd : nf));
  endtask
  task automatic t_regs();
    rchk("count reset", 0, REG_COUNT, CNT_RST);
    rchk("ctl reset", 1, REG_CTL, CTL_RST);
    wreg(1, REG_SRC_HI, 16'hFFFF);
    rchk("src hi", 1, REG_SRC_HI, 16'h000F);
    en = 0;
    wreg(0, REG_COUNT, 16'h5555);
    en = 1;
    rchk("frozen", 0, REG_COUNT, CNT_RST);
    wreg(0, REG_COUNT, 16'h1234);
    rchk("count ch1", 1, REG_COUNT, 16'h0000);
    rchk("unmapped", 0, 3'h6, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_word();
    int n0 = nd;
    setup(0, 20'h12340, 20'h00080, 16'h0002,
      ctlw(SYNC_NONE, RSRC_SW, STEP_INC, STEP_DEC, 1, 1, 1, 0, 0, 1));
    wait_n(1, n0 + 2);
    repeat (12) @(negedge clk);
    chk("dep addr", 20'h0007E, dep_a);
    chk("dep io", 20'h1, 20'(dio));
    chk("dep data", 20'(pat(20'h12342)), 20'(dep_d));
    rchk("src step", 0, REG_SRC_LO, 16'h2344);
    rchk("dst step", 0, REG_DST_LO, 16'h007C);
    rchk("count end", 0, REG_COUNT, 16'h0000);
    chk("disarm", 20'h0, 20'(armed[0]));
    chk("irq", 20'h1, 20'(irqs[0]));
    $display("t_word done");
  endtask
  task automatic t_byte();
    int n0 = nd;
    logic [7:0] b = 8'(pat(20'h00101) >> 8);
    wt = 3'h5;
    setup(1, 20'h00101, 20'h00200, 16'h0001,
      ctlw(SYNC_NONE, RSRC_SW, STEP_HOLD, STEP_INC, 0, 1, 0, 0, 0, 0));
    wait_n(1, n0 + 1);
    repeat (16) @(negedge clk);
    chk("odd lane", 20'h2, 20'(fbe));
    chk("even lane", 20'h1, 20'(dbe));
    chk("byte data", 20'({b, b}), 20'(dep_d));
    rchk("src held", 1, REG_SRC_LO, 16'h0101);
    rchk("dst byte", 1, REG_DST_LO, 16'h0201);
    chk("no irq", 20'h0, 20'(irqs[1]));
    chk("disarm", 20'h0, 20'(armed[1]));
    wt = 3'h0;
    $display("t_byte done");
  endtask
  task automatic t_block();
    int n0;
    for (int k = 0; k < 3; k++) begin
      hold = (k == 0);
      lock = (k == 1);
      nmi = (k == 2);
      n0 = nf;
      setup(0, 20'h00400, 20'h00500, 16'h0000,
        ctlw(SYNC_NONE, RSRC_SW, STEP_INC, STEP_INC, 1, 0, 0, 0, 0, 0));
      repeat (30) @(negedge clk);
      chk("blocked", 20'(n0), 20'(nf));
      chk("held off", 20'h2, 20'({breq, busy}));
      hold = 0;
      lock = 0;
      nmi = 0;
      repeat (30) @(negedge clk);
      chk("resumed", 20'h1, 20'(nf > n0 + 1));
      wreg(0, REG_CTL, CTL_RST);
      repeat (20) @(negedge clk);
      n0 = nf;
      repeat (30) @(negedge clk);
      chk("stopped", 20'(n0), 20'(nf));
      chk("idle", 20'h0, 20'({breq, busy}));
    end
    $display("t_block done");
  endtask
  task automatic t_arb();
    logic [15:0] c = ctlw(SYNC_NONE, RSRC_SW, 0, 0, 0, 0, 0, 0, 0, 0);
    setup(0, 20'h00600, 20'h00700, 16'h0000, c);
    setup(1, 20'h00610, 20'h00710, 16'h0000, c);
    repeat (60) @(negedge clk);
    chk("alternate", 20'h1, 20'(seq == 4'h5 || seq == 4'hA));
    wreg(1, REG_CTL, c | 16'h0010);
    repeat (60) @(negedge clk);
    chk("priority", 20'hF, 20'(seq));
    wreg(0, REG_CTL, CTL_RST);
    wreg(1, REG_CTL, CTL_RST);
    repeat (20) @(negedge clk);
    $display("t_arb done");
  endtask
  task automatic t_src();
    int n0 = nf;
    setup(0, 20'h00800, 20'h00900, 16'h0000,
      ctlw(SYNC_SRC, RSRC_PIN, 0, 0, 0, 0, 0, 0, 0, 0));
    repeat (20) @(negedge clk);
    chk("no request", 20'(n0), 20'(nf));
    pins[0] = 1;
    wait_n(0, n0 + 1);
    pins[0] = 0;
    repeat (30) @(negedge clk);
    chk("one fetch", 20'(n0 + 1), 20'(nf));
    n0 = nd;
    wreg(0, REG_CTL, ctlw(SYNC_SRC, RSRC_TMR, 0, 0, 0, 0, 0, 0, 0, 0));
    tmr = 1;
    @(negedge clk);
    tmr = 0;
    repeat (40) @(negedge clk);
    chk("timer", 20'(n0 + 1), 20'(nd));
    n0 = nd;
    wreg(0, REG_CTL, ctlw(SYNC_DST, RSRC_PIN, 0, 0, 0, 0, 0, 0, 0, 0));
    repeat (30) @(negedge clk);
    chk("dest wait", 20'(n0), 20'(nd));
    pins[0] = 1;
    wait_n(1, n0 + 1);
    pins[0] = 0;
    wreg(0, REG_CTL, CTL_RST);
    repeat (20) @(negedge clk);
    $display("t_src done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    t_regs();
    t_word();
    t_byte();
    t_block();
    t_arb();
    t_src();
    end_sim();
  end
endmodule
`default_nettype wire
